//--- logic/fps_pin_select.sv
/*
 * fps_pin_select: role selection of the four multiplexed serial flash
 * data pins, plus the data path that rides them on the serial clock.
 * assumes: core logic hands over command width, quad mode, write disable
 * and reset enable as levels; the serial clock is the link clock port and
 * chip select and pins are in that domain; the host keeps its own rules.
 */
`timescale 1ns/10ps
// Contract
// R01 - lane zero input single, bidirectional when wide
// R02 - lane one output single, bidirectional when wide
// R03 - lane two is write protect when allowed
// R04 - quad mode makes lane two data
// R05 - host drives write protect during register writes
// R06 - lane three data only quad and selected
// R07 - lane three is reset when enabled
// R08 - protected register writes silently dropped
// R09 - reset needs deselect and low pulse time
// R10 - sample rising, drive after falling or both
// R11 - deselected ignores inputs, floats outputs
module fps_pin_select #(
	parameter int RESET_PULSE = fps_pkg::RESET_PULSE_CYC
) (
	// system clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// link clock and chip select from the host
	input  wire logic       i_sck,
	input  wire logic       i_cs_n,
	// configuration from the core, system domain
	input  wire logic [1:0] i_cmd_width,
	input  wire logic       i_ddr,
	input  wire logic       i_quad_mode_bit,
	input  wire logic       i_status_write_disable_bit,
	input  wire logic       i_reset_enable_bit,
	input  wire logic       i_reg_write_cmd,
	input  wire logic       i_reg_target_sr1_cr1,
	// output nibble from the core, link domain
	input  wire logic [3:0] i_out_data,
	// pin inputs
	input  wire logic       i_lane_zero,
	input  wire logic       i_lane_one,
	input  wire logic       i_lane_two,
	input  wire logic       i_lane_three,
	// pin outputs and enables
	output logic      [3:0] o_lane_out,
	output logic      [3:0] o_lane_oe,
	// sampled input nibble, link domain
	output logic      [3:0] o_in_data,
	// decoded results, system domain
	output logic            o_write_protect_active,
	output logic            o_reg_write_blocked,
	output logic            o_hw_reset,
	output logic            o_cs_armed
);
	// configuration moved into link domain through two flops; the serial
	// clock stands still between frames, so a new setting is taken up only
	// after two rising edges of it: the core sets it ahead of the command
	logic [3:0] cfg_l;
	fps_sync #(.W(4), .RST_VAL(4'h0)) u_cfg_sync (
		.i_clk   (i_sck),
		.i_rst_n (i_rst_n),
		.i_d     ({i_ddr, i_quad_mode_bit, i_cmd_width}),
		.o_q     (cfg_l)
	);

	// chip select and the two role pins into system domain
	// reset value is the idle high level, so no false edge after reset
	logic [2:0] pin_s;
	fps_sync #(.W(3), .RST_VAL(3'h7)) u_pin_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_d     ({i_cs_n, i_lane_two, i_lane_three}),
		.o_q     (pin_s)
	);
	logic cs_n_s;
	logic wp_n_s;
	logic l3_s;
	assign cs_n_s = pin_s[2];
	assign wp_n_s = pin_s[1];
	assign l3_s   = pin_s[0];

	// link-side decode of width and role
	logic       ddr_l;
	logic       quad_l;
	logic [1:0] width_l;
	logic       wide_l;
	assign ddr_l   = cfg_l[3];
	assign quad_l  = cfg_l[2];
	assign width_l = cfg_l[1:0];
	assign wide_l  = (width_l != fps_pkg::WIDTH_SINGLE); // R01 R02
	logic       nibble_l;
	assign nibble_l = quad_l && (width_l == fps_pkg::WIDTH_QUAD); // R04 R06

	// pick output data bits per width; single uses lane one only
	logic [3:0] drv_data;
	logic [3:0] drv_en;
	assign drv_data = wide_l ? i_out_data : {2'h0, i_out_data[0], 1'h0};
	assign drv_en   = nibble_l ? 4'hf : (wide_l ? 4'h3 : 4'h2); // R01 R02 R04 R06

	// rising edge samples, inputs ignored while deselected
	logic [3:0] in_q;
	always_ff @(posedge i_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			in_q <= 4'h0;
		end else if (!i_cs_n) begin
			in_q <= {i_lane_three, i_lane_two, i_lane_one, i_lane_zero}; // R10 R11
		end
	end
	assign o_in_data = in_q;

	// output after falling edge; ddr also after rising edge
	logic [3:0] fall_q;
	logic [3:0] rise_q;
	always_ff @(negedge i_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fall_q <= 4'h0;
		end else begin
			fall_q <= drv_data; // R10
		end
	end
	always_ff @(posedge i_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rise_q <= 4'h0;
		end else begin
			rise_q <= drv_data; // R10
		end
	end

	// enables clear at once on deselect, floating every lane; on select they load at the next falling sck
	logic [3:0] en_q;
	always_ff @(negedge i_sck or posedge i_cs_n or negedge i_rst_n) begin
		if (!i_rst_n) begin
			en_q <= 4'h0;
		end else if (i_cs_n) begin
			en_q <= 4'h0; // R11
		end else begin
			en_q <= drv_en;
		end
	end

	// ddr shows the rising copy while the clock is high and the falling
	// copy while it is low; no single flop launches on both edges, so this
	// one mux stays, and sdr always shows the falling-edge flop directly
	logic ddr_hi;
	assign ddr_hi     = ddr_l && i_sck; // R10
	assign o_lane_out = ddr_hi ? rise_q : fall_q;
	assign o_lane_oe  = en_q;

	// system side: quad, write disable, reset enable from the core
	logic quad_s;
	logic wd_s;
	logic rst_en_s;
	assign quad_s   = i_quad_mode_bit;
	assign wd_s     = i_status_write_disable_bit;
	assign rst_en_s = i_reset_enable_bit;

	// lane two is write protect only with quad off and write disable set
	logic wp_role;
	assign wp_role = !quad_s && wd_s; // R03 R04
	// host keeps the pin driven during register writes, so level is valid
	logic wp_low;
	assign wp_low  = wp_role && !wp_n_s; // R05
	// protected writes to status or config one are dropped, no error
	logic block_w;
	assign block_w = wp_low && i_reg_write_cmd && i_reg_target_sr1_cr1; // R08

	// lane three role
	fps_pkg::fps_l3_role_e l3_role;
	assign l3_role = (quad_s && !cs_n_s) ? fps_pkg::FPS_L3_DATA : // R06
	                 (rst_en_s && (!quad_s || cs_n_s)) ? fps_pkg::FPS_L3_RESET : // R07
	                 fps_pkg::FPS_L3_UNUSED;
	logic rst_cond;
	assign rst_cond = (l3_role == fps_pkg::FPS_L3_RESET) && cs_n_s && !l3_s; // R07 R09

	// low pulse counter; a short pulse never resets
	logic [fps_pkg::RESET_CNT_W-1:0] rcnt_q;
	logic [fps_pkg::RESET_CNT_W-1:0] rcnt_d;
	logic                            rcnt_done;
	assign rcnt_done = (rcnt_q >= RESET_PULSE[fps_pkg::RESET_CNT_W-1:0]);
	assign rcnt_d    = !rst_cond ? '0 : (rcnt_done ? rcnt_q : rcnt_q + 1'b1);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rcnt_q <= '0;
		end else begin
			rcnt_q <= rcnt_d; // R09
		end
	end

	// a falling chip select after power up arms command decode
	logic cs_d1_q;
	logic armed_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cs_d1_q <= fps_pkg::RST_SYNC_VAL;
			armed_q <= 1'h0;
		end else begin
			cs_d1_q <= cs_n_s;
			// the select that ends a reset meets the still high reset flag
			if (cs_d1_q && !cs_n_s) begin
				armed_q <= 1'h1; // R11
			end else if (o_hw_reset) begin
				armed_q <= 1'h0;
			end
		end
	end

	// registered status outputs
	logic hw_rst_q;
	logic wp_q;
	logic blk_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hw_rst_q <= fps_pkg::RST_LOW;
			wp_q     <= fps_pkg::RST_LOW;
			blk_q    <= fps_pkg::RST_LOW;
		end else begin
			hw_rst_q <= rst_cond && rcnt_done; // R09
			wp_q     <= wp_low;
			blk_q    <= block_w; // R08
		end
	end
	assign o_hw_reset             = hw_rst_q;
	assign o_write_protect_active = wp_q;
	assign o_reg_write_blocked    = blk_q;
	assign o_cs_armed             = armed_q;
endmodule : fps_pin_select

//--- logic/fps_pkg.sv
/*
 * fps_pkg: constants shared by the serial flash pin function select block.
 * assumes: included before any module of the block; no import is used.
 */
package fps_pkg;
	// reset pulse least time and system clock figures
	localparam int RESET_PULSE_NS    = 200;
	localparam int CLK_PERIOD_NS     = 25;
	localparam int RESET_PULSE_CYC   = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_CNT_W       = 8;
	// command width codes
	localparam logic [1:0] WIDTH_SINGLE = 2'h0;
	localparam logic [1:0] WIDTH_DUAL   = 2'h1;
	localparam logic [1:0] WIDTH_QUAD   = 2'h2;
	// reset values
	localparam logic       RST_SYNC_VAL = 1'h1;
	localparam logic       RST_LOW      = 1'h0;
	// roles of the lane-three pin
	typedef enum logic [1:0] {
		FPS_L3_UNUSED = 2'b00,
		FPS_L3_DATA   = 2'b01,
		FPS_L3_RESET  = 2'b10
	} fps_l3_role_e;
endpackage : fps_pkg

//--- logic/fps_sync.sv
/*
 * fps_sync: two flip-flop level synchroniser into whatever clock drives i_clk (system clock or serial clock).
 * assumes: input is a quasi-static level from a pin or another domain.
 */
`timescale 1ns/10ps
module fps_sync #(
	parameter int          W        = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	// level in and out
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage read only by the second
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= i_d;
			sync_q <= meta_q;
		end
	end

	assign o_q = sync_q;
endmodule : fps_sync

//--- testbench/fps_checker.sv
/*
 * fps_checker: pin role assertions for fps_pin_select.
 * assumes: bound to fps_pin_select; config only changes while deselected.
 */
`timescale 1ns/10ps
module fps_checker #(
	parameter int RESET_PULSE = 3
) (
	// system clock and reset
	input wire logic       i_clk,
	input wire logic       i_rst_n,
	// select, configuration and role pins
	input wire logic       i_cs_n,
	input wire logic       i_quad_mode_bit,
	input wire logic       i_status_write_disable_bit,
	input wire logic       i_reset_enable_bit,
	input wire logic       i_reg_write_cmd,
	input wire logic       i_reg_target_sr1_cr1,
	input wire logic       i_lane_two,
	input wire logic       i_lane_three,
	// pin enables and decoded results
	input wire logic [3:0] o_lane_oe,
	input wire logic       o_write_protect_active,
	input wire logic       o_reg_write_blocked,
	input wire logic       o_hw_reset
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// status outputs lag the pins, so conditions are held a few cycles first
	sequence wp_held;
		(!i_quad_mode_bit && i_status_write_disable_bit && !i_lane_two) [*4];
	endsequence
	sequence rst_held;
		(i_cs_n && i_reset_enable_bit && !i_lane_three) [*8];
	endsequence
	a_float_deselected: assert property (i_cs_n |-> o_lane_oe == 4'h0)
		else $error("lanes driven while deselected");
	a_lane_two_data: assert property (o_lane_oe[2] |-> i_quad_mode_bit)
		else $error("lane two driven without quad mode");
	a_lane_three_data: assert property (o_lane_oe[3] |-> i_quad_mode_bit && !i_cs_n)
		else $error("lane three driven outside quad frame");
	a_wp_taken: assert property (wp_held |-> o_write_protect_active)
		else $error("write protect not taken");
	a_wp_quad_off: assert property (i_quad_mode_bit [*4] |-> !o_write_protect_active)
		else $error("write protect seen in quad mode");
	a_write_dropped: assert property ((wp_held and (i_reg_write_cmd && i_reg_target_sr1_cr1) [*4])
		|-> o_reg_write_blocked) else $error("protected write not dropped");
	a_reset_taken: assert property (rst_held |-> ##[0:4] o_hw_reset)
		else $error("reset pulse not recognised");
	a_reset_pulse: assert property ($rose(o_hw_reset) |-> !$past(i_lane_three, RESET_PULSE))
		else $error("reset recognised on short pulse");
endmodule : fps_checker

bind fps_pin_select fps_checker #(.RESET_PULSE(RESET_PULSE)) i_checker (.*);

//--- testbench/fps_host_model.sv
/*
 * fps_host_model: host controller side of the flash pins, clock and select.
 * assumes: device enables take priority over the host's own level.
 */
`timescale 1ns/10ps
module fps_host_model (
	// device pin drive
	input  wire logic [3:0] i_lane_out,
	input  wire logic [3:0] i_lane_oe,
	// host clock, select and resolved pins
	output logic            o_sck,
	output logic            o_cs_n,
	output logic      [3:0] o_lane
);
	logic [3:0] h_q = 4'hf;
	// host always drives a defined level; frame puts lane three high when deselecting
	assign o_lane = (i_lane_oe & i_lane_out) | (~i_lane_oe & h_q);
	// a few edges during reset, then the clock stands still between frames
	initial begin
		o_sck = 1'h0;
		o_cs_n = 1'h1;
		repeat (4) #24 o_sck = ~o_sck;
	end
	task pins(input logic cs, input logic [3:0] v);
		o_cs_n = cs;
		h_q = v;
	endtask : pins
	// one bit period at 48 ns, data set up well before the rising edge
	task frame(input logic [3:0] v);
		pins(1'h0, v);
		#24 o_sck = 1'h1;
		#24 o_sck = 1'h0;
		// lane three back high on deselect so no reset is seen
		#24 pins(1'h1, v | 4'h8);
	endtask : frame
endmodule : fps_host_model

//--- testbench/testbench.sv
/*
 * testbench: drives fps_pin_select beside a host model and checks pin roles.
 * assumes: fps_pkg, fps_pin_select, fps_host_model and fps_checker compiled.
 */
`timescale 1ns/10ps
module testbench;
	logic i_clk = 1'h0, i_rst_n = 1'h0, i_ddr = 1'h0, i_quad_mode_bit = 1'h0;
	logic i_status_write_disable_bit = 1'h0, i_reset_enable_bit = 1'h0;
	logic i_reg_write_cmd = 1'h0, i_reg_target_sr1_cr1 = 1'h0, sck, cs_n;
	logic o_write_protect_active, o_reg_write_blocked, o_hw_reset, o_cs_armed;
	logic [1:0] i_cmd_width = 2'h0;
	logic [3:0] i_out_data = 4'h0, b, o_lane_out, o_lane_oe, o_in_data, lane;
	logic [3:0] oe_exp, out_exp;
	logic [12:0] nt;
	integer seed = 1982, n_mismatch = 0, samples_checked = 0;
	logic [12:0] q[$];
	always #12.5 i_clk = ~i_clk;
	fps_pin_select #(.RESET_PULSE(3)) i_dut (.*, .i_sck(sck), .i_cs_n(cs_n),
		.i_lane_zero(lane[0]), .i_lane_one(lane[1]), .i_lane_two(lane[2]),
		.i_lane_three(lane[3]));
	fps_host_model i_host (.i_lane_out(o_lane_out), .i_lane_oe(o_lane_oe),
		.o_sck(sck), .o_cs_n(cs_n), .o_lane(lane));
	task check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task results;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results
	task step(input int n);
		repeat (n) @(negedge i_clk);
	endtask : step
	// scoreboard: oldest frame note against the pins once sck has fallen
	always @(negedge sck) begin
		if (!cs_n && q.size() > 0) begin
			#2;
			nt = q.pop_front();
			check("in", o_in_data, nt[3:0]);
			if (nt[12]) begin
				check("out", o_lane_out, nt[7:4]);
				check("oe", o_lane_oe, nt[11:8]);
			end
		end
	end
	// watchdog well beyond the few microseconds the sequence needs
	initial begin
		#20us;
		n_mismatch++;
		results();
	end
	initial begin
		step(5);
		i_rst_n = 1'h1;
		step(3);
		check("armed", 4'(o_cs_armed), 4'h0);
		// every width, quad mode last, random data both ways
		for (int m = 0; m < 4; m++) begin
			i_cmd_width = (m == 0) ? fps_pkg::WIDTH_SINGLE :
			              ((m == 1) ? fps_pkg::WIDTH_DUAL : fps_pkg::WIDTH_QUAD);
			i_quad_mode_bit = (m == 3);
			b = 4'($random(seed));
			i_ddr = b[0];
			// single drives lane one only; lanes two and three need quad mode
			oe_exp = (m == 0) ? 4'h2 : ((m == 3) ? 4'hf : 4'h3);
			for (int k = 0; k < 4; k++) begin
				b = 4'($random(seed));
				i_out_data = 4'($random(seed));
				out_exp = (m == 0) ? {2'h0, i_out_data[0], 1'h0} : i_out_data;
				// the stopped link clock needs one frame to take up a new width
				q.push_back({k > 0, oe_exp, out_exp, b});
				i_host.frame(b);
				step(1);
				check("oe", o_lane_oe, 4'h0);
			end
		end
		i_quad_mode_bit = 1'h0;
		i_cmd_width = fps_pkg::WIDTH_SINGLE;
		check("armed", 4'(o_cs_armed), 4'h1);
		// write protect low with write disable set, then high, then quad mode
		i_status_write_disable_bit = 1'h1;
		i_reg_write_cmd = 1'h1;
		i_reg_target_sr1_cr1 = 1'h1;
		i_host.pins(1'h1, 4'h0);
		step(8);
		check("wp", 4'(o_write_protect_active), 4'h1);
		check("blk", 4'(o_reg_write_blocked), 4'h1);
		i_host.pins(1'h1, 4'hf);
		step(8);
		check("blk", 4'(o_reg_write_blocked), 4'h0);
		i_quad_mode_bit = 1'h1;
		i_host.pins(1'h1, 4'h0);
		step(8);
		check("wp", 4'(o_write_protect_active), 4'h0);
		check("blk", 4'(o_reg_write_blocked), 4'h0);
		// reset: selected in quad mode, then a short pulse, then a full one
		i_reset_enable_bit = 1'h1;
		i_host.pins(1'h0, 4'h7);
		step(14);
		check("rst", 4'(o_hw_reset), 4'h0);
		i_quad_mode_bit = 1'h0;
		i_host.pins(1'h1, 4'h7);
		step(1);
		i_host.pins(1'h1, 4'hf);
		step(10);
		check("rst", 4'(o_hw_reset), 4'h0);
		i_host.pins(1'h1, 4'h7);
		step(14);
		check("rst", 4'(o_hw_reset), 4'h1);
		check("armed", 4'(o_cs_armed), 4'h0);
		results();
	end
endmodule : testbench
